/* src/adc_seq_pkg.sv */
// package: constants, control word layout and state types for the serial frame sequencer
package adc_seq_pkg;

  // ***************************************************************
  // frame timing, in serial clock falling edges
  // ***************************************************************
  localparam int FRAME_EDGES = 16;
  localparam int CTL_EDGES = 12;
  localparam int TRACK_EDGE = 14;
  localparam logic [4:0] CNT_RESET = 5'h00;

  // ***************************************************************
  // wake-up from automatic power-down, longest time rounds down
  // ***************************************************************
  localparam int CLK_PERIOD_NS = 40;
  localparam int WAKE_NS = 1000;
  localparam int WAKE_CYCLES = (WAKE_NS / CLK_PERIOD_NS) < 1 ? 1 : WAKE_NS / CLK_PERIOD_NS;

  // ***************************************************************
  // power selection codes {power_sel_hi, power_sel_lo}
  // ***************************************************************
  localparam logic [1:0] PWR_AUTO_DOWN = 2'h1;
  localparam logic [1:0] PWR_FULL_DOWN = 2'h2;
  localparam logic [1:0] PWR_NORMAL = 2'h3;

  // ***************************************************************
  // sequencer selection codes {seqEn, shadowEn}
  // ***************************************************************
  localparam logic [1:0] SEQ_OFF = 2'h0;
  localparam logic [1:0] SEQ_LOAD_SHADOW = 2'h1;
  localparam logic [1:0] SEQ_SHADOW = 2'h2;
  localparam logic [1:0] SEQ_CONSEC = 2'h3;

  // control word as captured on the first twelve falling edges, msb first
  typedef struct packed {
    logic writeEn;
    logic seqEn;
    logic spareHi;
    logic [2:0] chanAddr;
    logic powerSelHi;
    logic powerSelLo;
    logic shadowEn;
    logic spareLo;
    logic rangeSel;
    logic codingSel;
  } ctlWord_s;

  localparam ctlWord_s CTL_RESET = 12'h030;
  localparam logic [15:0] SHADOW_RESET = 16'h0000;

  // synchronised pin levels
  typedef struct packed {
    logic csN;
    logic sclk;
    logic din;
  } pins_s;

  typedef enum logic [1:0] {IDLE, FRAME, DONE} frame_e;

endpackage

/* src/adc_serial_frame_sequencer.sv */
// top: serial frame sequencer of an eight-channel 12-bit sampling converter
// ***************************************************************
// What this block does
// - serial clock drives conversion and shifting
// - chip-select fall: hold, sample, drive output
// - full frame is sixteen clocks; later clocks are ignored
// - track at edge 14, shadow frame at rise
// - output released on sixteenth falling edge
// - early rise aborts, output off, no update
// - word: zero, three address bits, result
// - zero at select, address msb edge one
// - last bit out at 15, valid 16
// - control captured on twelve edges if write
// - shadow programming captures next sixteen edges
// - shadow commits at rise, tracks first channel
// - reset loads normal power mode, so the first frame after power-up drives the output
// - auto power-down per frame, wake 1 us
// - full power-down wake frame, output undriven
// ***************************************************************
`timescale 1ns/1ps

module adc_serial_frame_sequencer (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // serial pins from the controller, asynchronous to clk_sys
  input wire logic csN,
  input wire logic sclk,
  input wire logic din,
  // serial data output pin
  output logic dout,
  output logic doutOe,
  // analog front end
  input wire logic [11:0] sampleData,
  output logic holdMode,
  output logic [2:0] muxChan,
  output logic powerDown,
  output logic frontEndReady,
  // configuration seen by the converter core
  output adc_seq_pkg::ctlWord_s ctlReg,
  output logic [15:0] shadowReg
);
  import adc_seq_pkg::*;

  // ***************************************************************
  // helpers
  // ***************************************************************
  // next set bit above cur, wrapping to the lowest; an empty mask keeps cur
  function automatic logic [2:0] nextChan(input logic [7:0] mask, input logic [2:0] cur);
    logic [2:0] res;
    logic found;
    logic [2:0] idx;
    res = cur;
    found = 1'b0;
    for (int i = 1; i <= 8; i++) begin
      idx = 3'(int'(cur) + i);
      if (!found && mask[idx]) begin
        res = idx;
        found = 1'b1;
      end
    end
    return res;
  endfunction

  // channels 0 up to and including top
  function automatic logic [7:0] upTo(input logic [2:0] top);
    logic [7:0] m;
    m = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (3'(i) <= top) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction

  // ***************************************************************
  // pin synchronisers
  // ***************************************************************
  pins_s meta_q, sync_q, prev_q;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      meta_q <= 3'h6;
      sync_q <= 3'h6;
      prev_q <= 3'h6;
    end else begin
      meta_q <= {csN, sclk, din};
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  logic csFall, csRise, sclkFall;
  assign csFall = prev_q.csN && !sync_q.csN;
  assign csRise = !prev_q.csN && sync_q.csN;
  // the serial clock is both conversion and shift clock
  assign sclkFall = prev_q.sclk && !sync_q.sclk && !sync_q.csN;

  // ***************************************************************
  // frame state
  // ***************************************************************
  frame_e state_q, state_d;
  logic [4:0] edgeCnt_q, edgeCnt_d;
  logic [15:0] outSh_q, outSh_d;
  logic [11:0] ctlSh_q, ctlSh_d;
  logic [15:0] shSh_q, shSh_d;
  logic oe_q, oe_d;
  logic hold_q, hold_d;
  logic shadowFrame_q, shadowFrame_d;
  logic shadowNext_q, shadowNext_d;
  logic [2:0] curChan_q, curChan_d;
  ctlWord_s ctl_q, ctl_d;
  logic [15:0] shadow_q, shadow_d;
  logic pdn_q, pdn_d;
  logic [5:0] wake_q, wake_d;
  logic [7:0] seqMask;
  ctlWord_s newCtl;

  always_comb begin
    // two sequence options are merged; a single sequence has a zero low byte
    seqMask = shadow_q[15:8] | shadow_q[7:0];
    if ({ctl_q.seqEn, ctl_q.shadowEn} == SEQ_CONSEC) begin
      seqMask = upTo(ctl_q.chanAddr);
    end
    newCtl = ctlSh_q;
    state_d = state_q;
    edgeCnt_d = edgeCnt_q;
    outSh_d = outSh_q;
    ctlSh_d = ctlSh_q;
    shSh_d = shSh_q;
    oe_d = oe_q;
    hold_d = hold_q;
    shadowFrame_d = shadowFrame_q;
    shadowNext_d = shadowNext_q;
    curChan_d = curChan_q;
    ctl_d = ctl_q;
    shadow_d = shadow_q;
    pdn_d = pdn_q;
    wake_d = (wake_q != 6'h00) ? wake_q - 6'h01 : wake_q;

    if (csFall) begin
      state_d = FRAME;
      edgeCnt_d = CNT_RESET;
      hold_d = 1'b1;
      // a wake-up write from full power-down leaves the line undriven
      oe_d = ({ctl_q.powerSelHi, ctl_q.powerSelLo} != PWR_FULL_DOWN);
      outSh_d = {1'b0, curChan_q, sampleData};
      ctlSh_d = 12'h000;
      shSh_d = 16'h0000;
      shadowFrame_d = shadowNext_q;
      shadowNext_d = 1'b0;
      // every select fall moves the mux on while a sequence runs
      if (ctl_q.seqEn) begin
        curChan_d = nextChan(seqMask, curChan_q);
      end
      if (pdn_q) begin
        pdn_d = 1'b0;
        wake_d = 6'(WAKE_CYCLES);
      end
    end else if (csRise) begin
      state_d = IDLE;
      oe_d = 1'b0;
      hold_d = 1'b0;
      if (edgeCnt_q == 5'(FRAME_EDGES)) begin
        if (shadowFrame_q) begin
          shadow_d = shSh_q;
          curChan_d = nextChan(shSh_q[15:8] | shSh_q[7:0], 3'h7);
        end else if (ctlSh_q[CTL_EDGES-1]) begin
          ctl_d = newCtl;
          case ({newCtl.seqEn, newCtl.shadowEn})
            SEQ_LOAD_SHADOW: shadowNext_d = 1'b1;
            SEQ_SHADOW: curChan_d = nextChan(seqMask, 3'h7);
            SEQ_CONSEC: curChan_d = 3'h0;
            default: curChan_d = newCtl.chanAddr;
          endcase
        end
      end
    end else if (state_q != IDLE && sclkFall) begin
      if (edgeCnt_q < 5'(FRAME_EDGES)) begin
        edgeCnt_d = edgeCnt_q + 5'h01;
        outSh_d = {outSh_q[14:0], 1'b0};
        if (!shadowFrame_q && edgeCnt_q < 5'(CTL_EDGES)) begin
          ctlSh_d = {ctlSh_q[10:0], sync_q.din};
        end
        if (shadowFrame_q) begin
          shSh_d = {shSh_q[14:0], sync_q.din};
        end
        if (edgeCnt_d == 5'(TRACK_EDGE) && !shadowFrame_q) begin
          hold_d = 1'b0;
        end
        if (edgeCnt_d == 5'(FRAME_EDGES)) begin
          oe_d = 1'b0;
          state_d = DONE;
          // auto power-down after each completed conversion
          if ({ctl_q.powerSelHi, ctl_q.powerSelLo} == PWR_AUTO_DOWN) begin
            pdn_d = 1'b1;
          end
        end
      end
    end

    // full power-down is held until the control word changes it
    if ({ctl_q.powerSelHi, ctl_q.powerSelLo} == PWR_FULL_DOWN && state_q == IDLE) begin
      pdn_d = 1'b1;
    end else if ({ctl_q.powerSelHi, ctl_q.powerSelLo} == PWR_NORMAL) begin
      pdn_d = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q <= IDLE;
      edgeCnt_q <= CNT_RESET;
      outSh_q <= 16'h0000;
      ctlSh_q <= 12'h000;
      shSh_q <= 16'h0000;
      oe_q <= 1'b0;
      hold_q <= 1'b0;
      shadowFrame_q <= 1'b0;
      shadowNext_q <= 1'b0;
      curChan_q <= 3'h0;
      ctl_q <= CTL_RESET;
      shadow_q <= SHADOW_RESET;
      pdn_q <= 1'b0;
      wake_q <= 6'h00;
    end else begin
      state_q <= state_d;
      edgeCnt_q <= edgeCnt_d;
      outSh_q <= outSh_d;
      ctlSh_q <= ctlSh_d;
      shSh_q <= shSh_d;
      oe_q <= oe_d;
      hold_q <= hold_d;
      shadowFrame_q <= shadowFrame_d;
      shadowNext_q <= shadowNext_d;
      curChan_q <= curChan_d;
      ctl_q <= ctl_d;
      shadow_q <= shadow_d;
      pdn_q <= pdn_d;
      wake_q <= wake_d;
    end
  end

  // ***************************************************************
  // outputs
  // ***************************************************************
  assign dout = outSh_q[15];
  assign doutOe = oe_q && !sync_q.csN;
  assign holdMode = hold_q;
  assign muxChan = curChan_q;
  assign powerDown = pdn_q;
  // results taken before the wake time has run out are not trustworthy
  assign frontEndReady = !pdn_q && (wake_q == 6'h00);
  assign ctlReg = ctl_q;
  assign shadowReg = shadow_q;

endmodule

/* verif/adc_seq_props.sv */
// checker: timing relations at the ports of the serial frame sequencer
`timescale 1ns/1ps

module adc_seq_props
  import adc_seq_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // serial pins
  input wire logic csN,
  input wire logic sclk,
  input wire logic dout,
  input wire logic doutOe,
  // front end and configuration
  input wire logic holdMode,
  input wire logic powerDown,
  input wire adc_seq_pkg::ctlWord_s ctlReg
);
  // ***************************************************************
  // serial clock falls counted at the pins, ahead of the design's sync
  // ***************************************************************
  logic [4:0] fallCnt_q, fallCnt_d;
  logic sclk_q, sclk_d, fallEv;
  assign fallEv = sclk_q && !sclk;
  always_comb begin
    sclk_d = sclk;
    fallCnt_d = fallCnt_q;
    if (csN) begin
      fallCnt_d = 5'h00;
    end else if (fallEv) begin
      fallCnt_d = fallCnt_q + 5'h01;
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fallCnt_q <= 5'h00;
      sclk_q <= 1'b1;
    end else begin
      fallCnt_q <= fallCnt_d;
      sclk_q <= sclk_d;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_csLow;
    $fell(csN) ##1 (!csN)[*5];
  endsequence
  property p_hold; s_csLow |-> holdMode && !dout; endproperty
  a_hold: assert property (p_hold) else $error("no hold or zero after select");
  property p_oeCs; csN[*3] |-> !doutOe; endproperty
  a_oeCs: assert property (p_oeCs) else $error("output driven while deselected");
  property p_oeEnd; fallEv && fallCnt_q == 5'h0F |-> ##[1:6] !doutOe; endproperty
  a_oeEnd: assert property (p_oeEnd) else $error("output kept after last fall");
  property p_track;
    fallEv && fallCnt_q == 5'h0D && {ctlReg.seqEn, ctlReg.shadowEn} != SEQ_LOAD_SHADOW
      |-> ##[1:6] !holdMode;
  endproperty
  a_track: assert property (p_track) else $error("no track after fall 14");
  property p_abort; $rose(csN) && fallCnt_q != 5'h10 |=> $stable(ctlReg)[*8]; endproperty
  a_abort: assert property (p_abort) else $error("short frame changed control");
  property p_commit; $changed(ctlReg) |-> csN && $past(csN, 3); endproperty
  a_commit: assert property (p_commit) else $error("control changed inside frame");
  property p_fullDown; ctlReg.powerSelHi && !ctlReg.powerSelLo |-> !doutOe; endproperty
  a_fullDown: assert property (p_fullDown) else $error("output driven in shutdown");
  property p_wake;
    powerDown && !ctlReg.powerSelHi && $fell(csN) |-> ##[1:6] !powerDown;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on select");
endmodule

bind adc_serial_frame_sequencer adc_seq_props u_adc_seq_props (.clk_sys(clk_sys), .rst(rst),
  .csN(csN), .sclk(sclk), .dout(dout), .doutOe(doutOe), .holdMode(holdMode),
  .powerDown(powerDown), .ctlReg(ctlReg));

/* verif/adc_ctl_master.sv */
// partner: serial port master driving select, clock and data in
`timescale 1ns/1ps

module adc_ctl_master (
  // serial pins
  output logic csN,
  output logic sclk,
  output logic din,
  input wire logic dout
);
  // ***************************************************************
  // frame task, clock idles high and stands still between frames
  // ***************************************************************
  initial begin
    csN = 1'b1;
    sclk = 1'b1;
    din = 1'b0;
  end
  task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
    r = 16'h0000;
    csN = 1'b0;
    din = w[15];
    #320;
    for (int k = 1; k <= n; k++) begin
      sclk = 1'b0;
      r = {r[14:0], dout};
      #160;
      sclk = 1'b1;
      if (k < 16) din = w[15-k];
      #160;
    end
    csN = 1'b1;
    din = ~din;
    // gap keeps 1 us of quiet time; valid conversions start 6.44 us apart
    #1000;
  endtask
endmodule

/* verif/tb_adc_serial_frame_sequencer.sv */
// testbench: frames, aborts, power modes and shadow load of the sequencer
`timescale 1ns/1ps

module tb_adc_serial_frame_sequencer;
  import adc_seq_pkg::*;
  // ***************************************************************
  // harness
  // ***************************************************************
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [11:0] sampleData = 12'hA5C;
  logic csN, sclk, din, dout, doutOe, holdMode, powerDown, frontEndReady, doutPin;
  logic [2:0] muxChan;
  ctlWord_s ctlReg;
  logic [15:0] shadowReg, rd;
  int err_count = 0;
  int total_checks = 0;
  int cycles = 0;
  always #20 clk_sys = ~clk_sys;
  adc_serial_frame_sequencer u_adc_serial_frame_sequencer (.clk_sys(clk_sys), .rst(rst),
    .csN(csN), .sclk(sclk), .din(din), .dout(dout), .doutOe(doutOe), .sampleData(sampleData),
    .holdMode(holdMode), .muxChan(muxChan), .powerDown(powerDown),
    .frontEndReady(frontEndReady),
    .ctlReg(ctlReg), .shadowReg(shadowReg));
  // a released line floats to its pull-up, so an undriven frame reads all ones
  assign doutPin = doutOe ? dout : 1'b1;
  adc_ctl_master u_adc_ctl_master (.csN(csN), .sclk(sclk), .din(din), .dout(doutPin));
  function automatic logic [15:0] ctl(logic [2:0] ch, logic [1:0] pwr, logic [1:0] sq);
    return {1'b1, sq[1], 1'b0, ch, pwr, sq[0], 3'h0, 4'h0};
  endfunction
  task chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task close_out();
    if (err_count == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      close_out();
    end
  end
  // ***************************************************************
  // scenarios
  // ***************************************************************
  task t_reset();
    chk({4'h0, ctlReg}, {4'h0, CTL_RESET});
    chk(shadowReg, SHADOW_RESET);
    chk({15'h0, doutOe}, 16'h0000);
  endtask
  task t_read();
    u_adc_ctl_master.xfer(ctl(3'h5, PWR_NORMAL, SEQ_OFF), 16, rd);
    chk(rd, {4'h0, sampleData});
    chk({4'h0, ctlReg}, ctl(3'h5, PWR_NORMAL, SEQ_OFF) >> 4);
    u_adc_ctl_master.xfer(16'h0000, 16, rd);
    chk(rd, {1'b0, 3'h5, sampleData});
    chk({4'h0, ctlReg}, ctl(3'h5, PWR_NORMAL, SEQ_OFF) >> 4);
  endtask
  task t_abort();
    u_adc_ctl_master.xfer(ctl(3'h2, PWR_NORMAL, SEQ_OFF), 9, rd);
    chk({4'h0, ctlReg}, ctl(3'h5, PWR_NORMAL, SEQ_OFF) >> 4);
    chk({13'h0, muxChan}, 16'h0005);
  endtask
  task t_power();
    u_adc_ctl_master.xfer(ctl(3'h5, PWR_AUTO_DOWN, SEQ_OFF), 16, rd);
    u_adc_ctl_master.xfer(16'h0000, 16, rd);
    chk({15'h0, powerDown}, 16'h0001);
    chk({15'h0, frontEndReady}, 16'h0000);
    u_adc_ctl_master.xfer(ctl(3'h5, PWR_FULL_DOWN, SEQ_OFF), 16, rd);
    chk({15'h0, frontEndReady}, 16'h0000);
    // wake-up write from full power-down: the line must stay released throughout
    u_adc_ctl_master.xfer(ctl(3'h5, PWR_NORMAL, SEQ_OFF), 16, rd);
    chk(rd, 16'hFFFF);
    chk({4'h0, ctlReg}, ctl(3'h5, PWR_NORMAL, SEQ_OFF) >> 4);
    chk({15'h0, powerDown}, 16'h0000);
    chk({15'h0, frontEndReady}, 16'h0001);
  endtask
  task t_shadow();
    u_adc_ctl_master.xfer(ctl(3'h0, PWR_NORMAL, SEQ_LOAD_SHADOW), 16, rd);
    // single sequence over channels 2 and 5, low byte left zero
    u_adc_ctl_master.xfer(16'h2400, 16, rd);
    chk(shadowReg, 16'h2400);
    chk({13'h0, muxChan}, 16'h0002);
  endtask
  task t_seq();
    u_adc_ctl_master.xfer(ctl(3'h0, PWR_NORMAL, SEQ_SHADOW), 16, rd);
    chk(rd, {1'b0, 3'h2, sampleData});
    chk({13'h0, muxChan}, 16'h0002);
    // valid frames back to back; an extra write here would skip a channel
    u_adc_ctl_master.xfer(16'h0000, 16, rd);
    chk(rd, {1'b0, 3'h2, sampleData});
    u_adc_ctl_master.xfer(16'h0000, 16, rd);
    chk(rd, {1'b0, 3'h5, sampleData});
    u_adc_ctl_master.xfer(ctl(3'h2, PWR_NORMAL, SEQ_CONSEC), 16, rd);
    chk(rd, {1'b0, 3'h2, sampleData});
    for (int i = 0; i < 4; i++) begin
      u_adc_ctl_master.xfer(16'h0000, 16, rd);
      chk(rd, {1'b0, 3'(i % 3), sampleData});
    end
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    #1 rst = 1'b0;
    repeat (4) @(posedge clk_sys);
    #1;
    t_reset();
    t_read();
    t_abort();
    t_power();
    t_shadow();
    t_seq();
    close_out();
  end
endmodule
